//--- msr_defines.svh
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH

// register byte offsets
`define MSR_OFS_CTRL     8'h00
`define MSR_OFS_TXMSG    8'h04
`define MSR_OFS_STATUS   8'h08

// control register fields
`define MSR_C_ECAP10G    0
`define MSR_C_ECAP1G     1
`define MSR_C_ECAP100    2
`define MSR_C_TRAIN_RST  3
`define MSR_C_FAST_RT    4
`define MSR_C_SHORT      5
`define MSR_C_LOOP       6
`define MSR_C_AB10G      7
`define MSR_C_AB1G_HD    8
`define MSR_C_AB1G_FD    9
`define MSR_C_MULTI      10
`define MSR_C_MAN_EN     11
`define MSR_C_MAN_VAL    12
`define MSR_CTRL_W       13
`define MSR_CTRL_RST     13'h0000

// status register fields
`define MSR_S_FAULT      0
`define MSR_S_MASTER     1
`define MSR_S_RESOLVED   2
`define MSR_S_CNT_LO     4
`define MSR_S_SEED_LO    8

// message code bit positions
`define MSR_U_ECAP10G    24
`define MSR_U_ECAP1G     23
`define MSR_U_ECAP100    22
`define MSR_U_TRAIN_RST  20
`define MSR_U_FAST_RT    19
`define MSR_U_SHORT      18
`define MSR_U_LOOP       17
`define MSR_U_AB10G      16
`define MSR_U_AB1G_HD    15
`define MSR_U_AB1G_FD    14
`define MSR_U_MULTI      13
`define MSR_U_MAN_VAL    12
`define MSR_U_MAN_EN     11

// seed handling
`define MSR_SEED_W       11
`define MSR_SEED_ALL1    11'h7ff
`define MSR_SEED_RST     11'h000
`define MSR_SEED_LIMIT   4'h7
`define MSR_LFSR_RST     16'hace1

// best common technology codes
`define MSR_TECH_NONE    2'h0
`define MSR_TECH_10G     2'h1
`define MSR_TECH_1G      2'h2

`endif

//--- msr_pkg.sv
package msr_pkg;

	// control flow states, one-hot
	typedef enum logic [3:0] {
		MSR_ST_BASE  = 4'h1, // waiting for base page exchange
		MSR_ST_XNP   = 4'h2, // waiting for partner technology page
		MSR_ST_CHECK = 4'h4, // page held, waiting for link good check
		MSR_ST_DONE  = 4'h8  // role resolved
	} msr_st_t;

	// classified device type of one page
	typedef enum logic [1:0] {
		MSR_SINGLE  = 2'h0,
		MSR_MULTI   = 2'h1,
		MSR_FMASTER = 2'h2,
		MSR_FSLAVE  = 2'h3
	} msr_type_t;

	// whole module state apart from the seeded flag
	typedef struct packed {
		msr_st_t     st;
		logic [12:0] ctrl;
		logic [31:0] peer;
		logic [10:0] seed;
		logic [3:0]  seed_cnt;
		logic [15:0] lfsr;
		logic [31:0] tx_msg;
		logic        fault;
		logic        master;
		logic        resolved;
		logic        link_fail;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} msr_state_t;

endpackage : msr_pkg

//--- msr_top.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "msr_defines.svh"

// How it works
// R1: technology page taken only after base page
// R2: message bits 31 to 25 sent zero
// R3: energy efficient bits mirror control settings
// R4: bit 20 carries training reset request
// R5: bits 19, 18 fast retrain, short reach
// R6: bit 17 only when loop timing advertised
// R7: bits 16 to 14 ability bits
// R8: classify page type from bits 11-13
// R9: manual value ignored unless manual enabled
// R10: resolve at good check, 10G/1G only
// R11: single loop timer becomes slave
// R12: multiport beats single, forced beats automatic
// R13: larger seed wins master
// R14: both forced same role sets fault
// R15: loop timing forcing conflict sets fault
// R16: equal seeds: fail link, new seed
// R17: seed counter counts generated seeds
// R18: completion clears counter, success also clears fault
// R19: fault after seventh seed unresolved
// R20: fault completes and fails the link
// R21: success sets role and clears fault
// R22: seed uniform over 0..2046, decorrelated
// R23: seeds compared as unsigned 11 bits
module msr_top #(
	parameter logic [15:0] LFSR_INIT = `MSR_LFSR_RST // free-running seed source start
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// negotiation side
	input  wire logic        an_restart,
	input  wire logic        base_page_done,
	input  wire logic        peer_page_valid,
	input  wire logic [31:0] peer_msg,
	input  wire logic        good_check_entry,
	input  wire logic [1:0]  best_common_tech,
	output logic [31:0]      tx_msg,
	output logic             link_state_flag,
	output logic             role_valid,
	output logic             role_master,
	output logic             cfg_fault
);
	import msr_pkg::*;

	msr_state_t cur;      // registered state
	msr_state_t next_cur; // next state

	// page type from bits 11..13 R8
	function automatic msr_type_t classify(input logic en, input logic val, input logic multi);
		msr_type_t t;
		t = MSR_SINGLE;
		if (en) begin
			t = val ? MSR_FMASTER : MSR_FSLAVE; // R8
		end else if (multi) begin
			t = MSR_MULTI; // R8
		end
		return t;
	endfunction : classify

	// resolution decision wires
	msr_type_t  lt;        // local type
	msr_type_t  rt;        // remote type
	logic       lloop;     // local loop timing
	logic       rloop;     // remote loop timing
	logic [10:0] rseed;    // remote seed
	logic       res_fault; // configuration fault
	logic       res_tie;   // identical seeds
	logic       res_mst;   // local is master
	logic [10:0] new_seed; // candidate fresh seed
	logic       wr_hit;    // apb write commit
	logic       rd_setup;  // apb setup phase
	logic       tech_ok;   // twisted-pair common technology
	logic       seeded;    // startup seed taken

	// resolution table, pure combinational
	always_comb begin
		lt = classify(cur.ctrl[`MSR_C_MAN_EN], cur.ctrl[`MSR_C_MAN_VAL], cur.ctrl[`MSR_C_MULTI]); // R9
		rt = classify(cur.peer[`MSR_U_MAN_EN], cur.peer[`MSR_U_MAN_VAL], cur.peer[`MSR_U_MULTI]); // R8
		lloop = cur.ctrl[`MSR_C_LOOP];
		rloop = cur.peer[`MSR_U_LOOP];
		rseed = cur.peer[10:0]; // R23
		res_fault = 1'b0;
		res_tie = 1'b0;
		res_mst = 1'b0;
		if (lloop != rloop) begin
			// loop timing side is slave, the other master R11
			res_mst = !lloop;
			// forcing against that outcome is a fault R15
			if (lloop) begin
				res_fault = (lt == MSR_FMASTER) || (rt == MSR_FSLAVE); // R15
			end else begin
				res_fault = (rt == MSR_FMASTER) || (lt == MSR_FSLAVE); // R15
			end
		end else if (lt == rt && (lt == MSR_FMASTER || lt == MSR_FSLAVE)) begin
			res_fault = 1'b1; // R14
		end else if (lt == MSR_FMASTER || rt == MSR_FSLAVE) begin
			res_mst = 1'b1; // R12
		end else if (lt == MSR_FSLAVE || rt == MSR_FMASTER) begin
			res_mst = 1'b0; // R12
		end else if (lt != rt) begin
			res_mst = (lt == MSR_MULTI); // R12
		end else if (cur.seed == rseed) begin
			res_tie = 1'b1; // R16
		end else begin
			res_mst = cur.seed > rseed; // R13 R23
		end
	end

	// fresh seed from lfsr, all ones folded away to stay in 0..2046
	always_comb begin
		new_seed = cur.lfsr[10:0] ^ cur.lfsr[15:5];
		if (new_seed == `MSR_SEED_ALL1) begin
			new_seed = cur.lfsr[10:0] & 11'h3ff; // R22
		end
	end

	assign rd_setup = psel && !penable;
	assign wr_hit = psel && penable && cur.pready && pwrite;

	// only 10G or 1000 twisted pair lets the role table run R10
	assign tech_ok = (best_common_tech == `MSR_TECH_10G) || (best_common_tech == `MSR_TECH_1G);

	// next state of everything
	always_comb begin
		next_cur = cur;
		next_cur.link_fail = 1'b0; // fail request is a one-cycle pulse
		// free-running lfsr; partner seed mixed in so twin devices diverge
		next_cur.lfsr = {cur.lfsr[14:0], cur.lfsr[15] ^ cur.lfsr[13] ^ cur.lfsr[12] ^ cur.lfsr[10]};
		if (peer_page_valid) begin
			next_cur.lfsr[10:0] = next_cur.lfsr[10:0] ^ peer_msg[10:0]; // R22
		end
		// the partner mix can land on all zeros, where the lfsr would stick
		if (next_cur.lfsr == 16'h0000) begin
			next_cur.lfsr = LFSR_INIT; // R22
		end

		// apb: answer one cycle after setup
		next_cur.pready = rd_setup;
		next_cur.pslverr = 1'b0;
		next_cur.prdata = 32'h0000_0000;
		if (rd_setup) begin
			case (paddr)
				`MSR_OFS_CTRL: begin
					next_cur.prdata = {19'h00000, cur.ctrl};
				end
				`MSR_OFS_TXMSG: begin
					next_cur.prdata = cur.tx_msg;
				end
				`MSR_OFS_STATUS: begin
					next_cur.prdata = {13'h0000, cur.seed, cur.seed_cnt, 1'b0,
						cur.resolved, cur.master, cur.fault};
				end
				default: begin
					next_cur.pslverr = 1'b1; // unmapped address
				end
			endcase
		end
		if (wr_hit && paddr == `MSR_OFS_CTRL) begin
			next_cur.ctrl = pwdata[12:0];
		end

		// outgoing technology page
		next_cur.tx_msg = 32'h0000_0000; // R2
		next_cur.tx_msg[`MSR_U_ECAP10G] = cur.ctrl[`MSR_C_ECAP10G]; // R3
		next_cur.tx_msg[`MSR_U_ECAP1G] = cur.ctrl[`MSR_C_ECAP1G]; // R3
		next_cur.tx_msg[`MSR_U_ECAP100] = cur.ctrl[`MSR_C_ECAP100]; // R3
		next_cur.tx_msg[`MSR_U_TRAIN_RST] = cur.ctrl[`MSR_C_TRAIN_RST]; // R4
		next_cur.tx_msg[`MSR_U_FAST_RT] = cur.ctrl[`MSR_C_FAST_RT]; // R5
		next_cur.tx_msg[`MSR_U_SHORT] = cur.ctrl[`MSR_C_SHORT]; // R5
		next_cur.tx_msg[`MSR_U_LOOP] = cur.ctrl[`MSR_C_LOOP]; // R6
		next_cur.tx_msg[`MSR_U_AB10G] = cur.ctrl[`MSR_C_AB10G]; // R7
		next_cur.tx_msg[`MSR_U_AB1G_HD] = cur.ctrl[`MSR_C_AB1G_HD]; // R7
		next_cur.tx_msg[`MSR_U_AB1G_FD] = cur.ctrl[`MSR_C_AB1G_FD]; // R7
		next_cur.tx_msg[`MSR_U_MULTI] = cur.ctrl[`MSR_C_MULTI];
		next_cur.tx_msg[`MSR_U_MAN_EN] = cur.ctrl[`MSR_C_MAN_EN];
		// value only meaningful with manual enable R9
		next_cur.tx_msg[`MSR_U_MAN_VAL] = cur.ctrl[`MSR_C_MAN_VAL] & cur.ctrl[`MSR_C_MAN_EN]; // R9
		next_cur.tx_msg[10:0] = cur.seed;

		// negotiation flow
		case (cur.st)
			MSR_ST_BASE: begin
				if (base_page_done) begin
					next_cur.st = MSR_ST_XNP; // R1
				end
			end
			MSR_ST_XNP: begin
				// partner technology page follows the base page R1
				if (peer_page_valid) begin
					next_cur.peer = peer_msg;
					next_cur.st = MSR_ST_CHECK;
				end
			end
			MSR_ST_CHECK: begin
				if (good_check_entry) begin
					next_cur.st = MSR_ST_BASE;
					// only 10G or 1000 twisted pair resolves a role R10
					if (tech_ok) begin // R10
						if (res_fault) begin
							// fault completes resolution but fails the link R20
							next_cur.fault = 1'b1; // R14 R15
							next_cur.seed_cnt = 4'h0; // R18
							next_cur.link_fail = 1'b1; // R20
						end else if (res_tie) begin
							next_cur.link_fail = 1'b1; // R16
							if (cur.seed_cnt >= `MSR_SEED_LIMIT) begin
								// seven seeds spent without a result R19
								next_cur.fault = 1'b1; // R19
								next_cur.seed_cnt = 4'h0; // R18
							end else begin
								next_cur.seed = new_seed; // R16 R22
								next_cur.seed_cnt = cur.seed_cnt + 4'h1; // R17
							end
						end else begin
							next_cur.fault = 1'b0; // R18 R21
							next_cur.seed_cnt = 4'h0; // R18
							next_cur.master = res_mst; // R21
							next_cur.resolved = 1'b1; // R21
							next_cur.st = MSR_ST_DONE;
						end
					end
				end
			end
			MSR_ST_DONE: begin
				// role stays until a new negotiation starts
			end
			default: begin
				next_cur.st = MSR_ST_BASE;
			end
		endcase

		// restart from the negotiation engine drops any held role
		if (an_restart) begin
			next_cur.st = MSR_ST_BASE;
			next_cur.resolved = 1'b0;
		end

		// first seed drawn once after release, not counted as an attempt
		if (!seeded) begin
			next_cur.seed = new_seed; // R17 R22
		end
	end

	// one register for all state but the seeded flag
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cur <= '{st: MSR_ST_BASE, ctrl: `MSR_CTRL_RST, peer: 32'h0000_0000,
				seed: `MSR_SEED_RST, seed_cnt: 4'h0, lfsr: LFSR_INIT,
				tx_msg: 32'h0000_0000, fault: 1'b0, master: 1'b0, resolved: 1'b0,
				link_fail: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000}; // R17
			seeded <= 1'b0;
		end else begin
			cur <= next_cur;
			seeded <= 1'b1;
		end
	end

	// outputs straight from the state register
	assign pready = cur.pready;
	assign prdata = cur.prdata;
	assign pslverr = cur.pslverr;
	assign tx_msg = cur.tx_msg;
	assign link_state_flag = cur.link_fail;
	assign role_valid = cur.resolved;
	assign role_master = cur.master;
	assign cfg_fault = cur.fault;

	// checks, all on the system clock and quiet during reset
	// reserved message bits never leave the block set
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
		tx_msg[31:25] == 7'h00 && tx_msg[21] == 1'b0) else $error("reserved bits set");
	// energy bits follow control one cycle later, in page order
	a_ecap_mirror: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
		##1 tx_msg[24:22] == $past({cur.ctrl[`MSR_C_ECAP10G], cur.ctrl[`MSR_C_ECAP1G], cur.ctrl[`MSR_C_ECAP100]}))
		else $error("energy bits wrong");
	// training reset request follows control
	a_train_mirror: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
		##1 tx_msg[`MSR_U_TRAIN_RST] == $past(cur.ctrl[`MSR_C_TRAIN_RST]))
		else $error("training request wrong");
	// fast retrain and short reach follow control
	a_reach_mirror: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
		##1 tx_msg[`MSR_U_FAST_RT] == $past(cur.ctrl[`MSR_C_FAST_RT])
		&& tx_msg[`MSR_U_SHORT] == $past(cur.ctrl[`MSR_C_SHORT]))
		else $error("retrain or reach bit wrong");
	// loop timing bit only while advertised
	a_loop_adv: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
		##1 tx_msg[`MSR_U_LOOP] == $past(cur.ctrl[`MSR_C_LOOP]))
		else $error("loop timing bit wrong");
	// ability bits follow control, 10G first
	a_ability_bits: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
		##1 tx_msg[16:14] == $past({cur.ctrl[`MSR_C_AB10G], cur.ctrl[`MSR_C_AB1G_HD], cur.ctrl[`MSR_C_AB1G_FD]}))
		else $error("ability bits wrong");
	// value bit is masked unless manual enable is sent
	a_man_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
		!tx_msg[`MSR_U_MAN_EN] |-> !tx_msg[`MSR_U_MAN_VAL]) else $error("manual value leaked");
	// the page carries the current seed in its low bits
	a_seed_sent: assert property (@(posedge clk_sys) disable iff (!resetn) // R23
		##1 tx_msg[10:0] == $past(cur.seed)) else $error("seed not sent");
	// all ones is never used as a seed
	a_seed_range: assert property (@(posedge clk_sys) disable iff (!resetn) // R22
		seeded |-> cur.seed != `MSR_SEED_ALL1) else $error("seed out of range");
	// the page state is entered only from the wait for the partner page
	a_page_order: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
		cur.st == MSR_ST_CHECK && $past(cur.st) != MSR_ST_CHECK
		|-> $past(cur.st) == MSR_ST_XNP && $past(peer_page_valid))
		else $error("page taken out of order");
	// a role appears only after a good check with twisted-pair technology
	a_resolve_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
		$rose(role_valid) |-> $past(good_check_entry) && $past(cur.st == MSR_ST_CHECK) && $past(tech_ok))
		else $error("role resolved outside good check");
	// other technologies leave fault and link alone
	a_no_tech: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
		cur.st == MSR_ST_CHECK && good_check_entry && !tech_ok |=> !link_state_flag && $stable(cfg_fault))
		else $error("resolved without twisted pair");
	// success leaves no fault and no spent seeds
	a_success_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
		$rose(role_valid) |-> !cfg_fault && cur.seed_cnt == 4'h0) else $error("success left fault");
	// the fault bit drops only together with a fresh role
	a_fault_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // R21
		$fell(cfg_fault) |-> $rose(role_valid)) else $error("fault cleared without success");
	// a fault fails the link and gives no role
	a_fault_fails: assert property (@(posedge clk_sys) disable iff (!resetn) // R20
		$rose(cfg_fault) |-> link_state_flag && !role_valid) else $error("fault without link fail");
	// the fail request is one cycle long
	a_link_pulse: assert property (@(posedge clk_sys) disable iff (!resetn) // R20
		link_state_flag |=> !link_state_flag) else $error("link fail held");
	// the role does not move while it is valid
	a_role_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // R21
		role_valid && $past(role_valid) |-> $stable(role_master)) else $error("role changed while valid");
	// the loop timing side ends as slave
	a_loop_slave: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
		$rose(role_valid) && $past(lloop) && !$past(rloop) |-> !role_master)
		else $error("loop timing side not slave");
	// loop timing side forced to master is a fault
	a_loop_fault: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
		cur.st == MSR_ST_CHECK && good_check_entry && tech_ok && lloop && !rloop && lt == MSR_FMASTER
		|=> cfg_fault && link_state_flag) else $error("loop timing master not a fault");
	// both forced to one role is a fault
	a_forced_clash: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
		cur.st == MSR_ST_CHECK && good_check_entry && tech_ok && lloop == rloop && lt == rt
		&& (lt == MSR_FMASTER || lt == MSR_FSLAVE) |=> cfg_fault && link_state_flag)
		else $error("forced clash not a fault");
	// multiport beats single port
	a_multi_wins: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
		cur.st == MSR_ST_CHECK && good_check_entry && tech_ok && !an_restart && lloop == rloop
		&& lt == MSR_MULTI && rt == MSR_SINGLE |=> role_valid && role_master)
		else $error("multiport lost master");
	// same type: the larger seed is master
	a_seed_wins: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
		cur.st == MSR_ST_CHECK && good_check_entry && tech_ok && !an_restart && lloop == rloop && lt == rt
		&& (lt == MSR_SINGLE || lt == MSR_MULTI) && cur.seed != rseed
		|=> role_valid && role_master == $past(cur.seed > rseed)) else $error("seed order not kept");
	// a tie fails the link and counts one more seed
	a_seed_count: assert property (@(posedge clk_sys) disable iff (!resetn) // R16 R17
		cur.st == MSR_ST_CHECK && good_check_entry && res_tie && !res_fault
		&& cur.seed_cnt < `MSR_SEED_LIMIT && tech_ok
		|=> cur.seed_cnt == $past(cur.seed_cnt) + 4'h1 && link_state_flag)
		else $error("seed counter not advanced");
	// a tie with seven seeds spent is a fault
	a_tie_cap: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
		cur.st == MSR_ST_CHECK && good_check_entry && tech_ok && res_tie && cur.seed_cnt == `MSR_SEED_LIMIT
		|=> cfg_fault && link_state_flag && cur.seed_cnt == 4'h0) else $error("seventh seed not a fault");
	// the counter never runs past its limit
	a_seed_cap: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
		cur.seed_cnt <= `MSR_SEED_LIMIT) else $error("seed counter past limit");
	// every apb access answers one cycle after setup, for one cycle
	a_apb_answer: assert property (@(posedge clk_sys) disable iff (!resetn) // apb handshake timing, not one of the rules
		psel && !penable |=> pready ##1 !pready) else $error("apb answer timing");
endmodule : msr_top

//--- msr_peer_model.sv
`timescale 1ns/100ps
// partner negotiation model: base page, then technology page, then good check
module msr_peer_model (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        go,               // start one page exchange
	input  wire logic [31:0] msg,              // partner technology page
	input  wire logic [1:0]  tech,             // best common technology to report
	output logic             base_page_done,
	output logic             peer_page_valid,
	output logic [31:0]      peer_msg,
	output logic             good_check_entry,
	output logic [1:0]       best_common_tech
);
	// one stage per cycle, so the pages always come in exchange order
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			base_page_done   <= 1'b0;
			peer_page_valid  <= 1'b0;
			good_check_entry <= 1'b0;
			peer_msg         <= 32'h0;
			best_common_tech <= 2'h0;
		end else begin
			base_page_done   <= go;
			peer_page_valid  <= base_page_done;
			good_check_entry <= peer_page_valid;
			// unqualified page bus toggles, so stale data is never trusted
			peer_msg         <= base_page_done ? msg : ~peer_msg;
			best_common_tech <= peer_page_valid ? tech : ~best_common_tech;
		end
	end
endmodule : msr_peer_model

//--- master_slave_resolution_tb.sv
`timescale 1ns/100ps
module master_slave_resolution_tb;
	import msr_pkg::*;
	logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, an_restart, go, er;
	logic        bpd, ppv, gce, link_state_flag, role_valid, role_master, cfg_fault;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, tx_msg, peer_msg, pmsg, rd, lf, p;
	logic [1:0]  tech, bct;
	logic [12:0] c;
	logic [10:0] ls;
	logic [2:0]  r;
	int          n_fail, comparisons, cyc, k;

	msr_top msr_top_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.an_restart(an_restart), .base_page_done(bpd), .peer_page_valid(ppv), .peer_msg(peer_msg),
		.good_check_entry(gce), .best_common_tech(bct), .tx_msg(tx_msg), .link_state_flag(link_state_flag),
		.role_valid(role_valid), .role_master(role_master), .cfg_fault(cfg_fault));
	msr_peer_model msr_peer_model_i (.clk_sys(clk_sys), .resetn(resetn), .go(go), .msg(pmsg), .tech(tech),
		.base_page_done(bpd), .peer_page_valid(ppv), .peer_msg(peer_msg), .good_check_entry(gce),
		.best_common_tech(bct));

	// 125 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// expected page bits 31:13 and 11; bit 12 left out, its use is the partner's
	function automatic logic [31:0] exp_tx(input logic [12:0] v);
		exp_tx = 32'h0;
		exp_tx[24:22] = {v[0], v[1], v[2]};
		exp_tx[20] = v[3];
		exp_tx[19:18] = {v[4], v[5]};
		exp_tx[17] = v[6];
		exp_tx[16:14] = {v[7], v[8], v[9]};
		exp_tx[13] = v[10];
		exp_tx[11] = v[11];
	endfunction : exp_tx

	// expected outcome {tie, fault, master}
	function automatic logic [2:0] exp_res(input logic [12:0] v, input logic [10:0] s, input logic [31:0] m);
		logic lfm, lfs, pfm, pfs;
		lfm = v[11] & v[12];
		lfs = v[11] & !v[12];
		pfm = m[11] & m[12];
		pfs = m[11] & !m[12];
		if (v[6] != m[17]) return {1'b0, v[6] ? (lfm | pfs) : (pfm | lfs), !v[6]};
		if ((lfm & pfm) | (lfs & pfs)) return 3'b010;
		if (lfm | pfs) return 3'b001;
		if (lfs | pfm) return 3'b000;
		if (v[10] != m[13]) return {2'b00, v[10]};
		if (s == m[10:0]) return 3'b100;
		return {2'b00, s > m[10:0]};
	endfunction : exp_res

	task final_report;
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// restart, then one page exchange; returns just after the answering edge
	task nego(input logic [31:0] m, input logic [1:0] t);
		pmsg <= m;
		tech <= t;
		@(posedge clk_sys);
		an_restart <= 1'b1;
		@(posedge clk_sys);
		an_restart <= 1'b0;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		do @(posedge clk_sys); while (gce !== 1'b1);
		#1;
	endtask : nego

	// hang guard, far above the well under one thousand cycles the run needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report;
		end
	end

	initial begin
		{psel, penable, pwrite, an_restart, go} = 5'h0;
		{paddr, pwdata, pmsg, tech} = 74'h0;
		lf = 32'hcaf7;
		resetn = 1'b0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(rd[7:0]), 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		// repeated equal seeds: counter climbs, eighth tie gives up with a fault
		for (k = 1; k <= 8; k++) begin
			ls = tx_msg[10:0];
			chk(32'(ls == 11'h7ff), 32'h0);
			nego({21'h0, ls}, 2'h1);
			chk(32'({link_state_flag, role_valid}), 32'h2);
			chk(32'(cfg_fault), 32'(k == 8));
			apb(1'b0, 8'h08, 32'h0);
			chk(32'(rd[7:4]), 32'(k % 8));
		end
		// no twisted-pair common technology: nothing resolves
		for (k = 0; k < 2; k++) begin
			nego(32'h0, k ? 2'h3 : 2'h0);
			chk(32'({link_state_flag, role_valid, cfg_fault}), 32'h1);
		end
		// random local and partner setups, seeds one bit apart
		for (k = 0; k < 32; k++) begin
			lf = lfsr_next(lf);
			c = lf[12:0];
			apb(1'b1, 8'h00, {19'h0, c});
			repeat (2) @(posedge clk_sys);
			#1;
			chk(tx_msg & 32'hffffe800, exp_tx(c));
			apb(1'b0, 8'h04, 32'h0);
			chk(rd & 32'hffffe800, exp_tx(c));
			ls = tx_msg[10:0];
			lf = lfsr_next(lf);
			p = (lf & 32'h00023800) | {21'h0, ls ^ (11'h1 << (lf[31:28] % 11))};
			r = exp_res(c, ls, p);
			nego(p, k[0] ? 2'h2 : 2'h1);
			chk(32'(cfg_fault), 32'(r[1]));
			chk(32'({link_state_flag, role_valid}), 32'({r[1], !r[1]}));
			if (!r[1]) chk(32'(role_master), 32'(r[0]));
			apb(1'b0, 8'h08, 32'h0);
			chk(32'({rd[7:4], rd[2], rd[0]}), 32'({!r[1], r[1]}));
			chk(32'(rd[18:8]), 32'(ls));
			if (!r[1]) chk(32'(rd[1]), 32'(r[0]));
		end
		final_report;
	end
endmodule : master_slave_resolution_tb
